// [frt_timer.sv]
// free-running 16-bit timer with compare output and capture
`timescale 1ns/1ps
`default_nettype none
`include "frt_params.svh"

module frt_timer (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // cpu side
    frt_bus_if.dev bus,
    // count source from the 8-bit timer
    input wire logic ext_tick,
    // shared pin
    input wire logic snapshot_in_pin,
    input wire logic pin_latch,
    output logic wave_out_pin,
    output logic wave_out_oe
);
    logic [15:0] free_counter;
    logic [15:0] match_reg;
    logic [15:0] snapshot_reg;
    logic [15:0] rbuf_reg;
    logic [7:0] mode_ctrl_reg;
    logic [7:0] port_dir_reg;
    logic [7:0] match_lo_reg;
    logic [4:0] div_reg;
    logic frozen_reg;
    logic hi_rd_reg;
    logic level_reg;
    logic tick;
    logic rise;
    logic fall;
    logic edge_hit;
    logic match_hit;
    logic [7:0] rdata_next;
    frt_pkg::frt_clk_e clk_sel;
    frt_pkg::frt_edge_e edge_sel;

    assign clk_sel = frt_pkg::frt_clk_e'(mode_ctrl_reg[`FRT_B_CLK_HI:
        `FRT_B_CLK_LO]);
    assign edge_sel = frt_pkg::frt_edge_e'(mode_ctrl_reg[`FRT_B_EDGE_HI:
        `FRT_B_EDGE_LO]);

    // prescaler runs freely so divided ticks stay evenly spaced
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            div_reg <= 5'h00;
        else
            div_reg <= div_reg + 5'h01;
    end

    always_comb begin
        case (clk_sel)
            frt_pkg::frt_clk_ext: tick = ext_tick;
            frt_pkg::frt_clk_main: tick = 1'b1;
            frt_pkg::frt_clk_div4: tick = (div_reg[1:0] == 2'h3);
            frt_pkg::frt_clk_div32: tick = (div_reg == 5'h1f);
            default: tick = 1'b0;
        endcase
    end

    // never cleared by a match, so the period is the full wrap
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            free_counter <= `FRT_RST_COUNT;
        else if (tick)
            free_counter <= free_counter + 16'h0001;
    end

    // one pulse per count-clock period at the matching value
    assign match_hit = tick && (free_counter == match_reg);
    assign bus.match_irq = match_hit;

    // match value: low byte staged, committed with the high byte
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            match_reg <= `FRT_RST_MATCH;
            match_lo_reg <= 8'hff;
        end else if (bus.wr && bus.addr == `FRT_OFF_MATCH_LO) begin
            match_lo_reg <= bus.wdata;
        end else if (bus.wr && bus.addr == `FRT_OFF_MATCH_HI) begin
            match_reg <= {bus.wdata, match_lo_reg};
        end
    end

    // mode register; wrap flag set wins over software clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_ctrl_reg <= `FRT_RST_MODE;
        end else begin
            if (bus.wr && bus.addr == `FRT_OFF_MODE)
                mode_ctrl_reg[`FRT_B_WRAP:0] <= bus.wdata[`FRT_B_WRAP:0];
            if (tick && free_counter == 16'hffff)
                mode_ctrl_reg[`FRT_B_WRAP] <= 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            port_dir_reg <= `FRT_RST_PORT_DIR;
        else if (bus.wr && bus.addr == `FRT_OFF_PORT_DIR)
            port_dir_reg <= {3'b111, bus.wdata[4:0]}; // top three absent
    end

    // output level: forced low while disabled so enabling starts low
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            level_reg <= 1'b0;
        else if (!mode_ctrl_reg[`FRT_B_OUT_EN])
            level_reg <= 1'b0;
        else if (match_hit && mode_ctrl_reg[`FRT_B_TOGGLE])
            level_reg <= ~level_reg;
    end

    // pin driver; software owns direction and latch
    assign wave_out_oe = ~port_dir_reg[`FRT_B_PIN_DIR];
    assign wave_out_pin = mode_ctrl_reg[`FRT_B_OUT_EN] ? level_reg
        : pin_latch;

    frt_edge_det u_edge (
        .pclk(pclk),
        .presetn(presetn),
        .pin_in(snapshot_in_pin),
        .rise(rise),
        .fall(fall)
    );

    always_comb begin
        case (edge_sel)
            frt_pkg::frt_edge_rise: edge_hit = rise;
            frt_pkg::frt_edge_fall: edge_hit = fall;
            frt_pkg::frt_edge_both: edge_hit = rise | fall;
            default: edge_hit = 1'b0;
        endcase
    end

    // capture lands one clock after the detected edge, except while frt_clk_main is selected
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            snapshot_reg <= 16'h0000;
        else if (edge_hit && clk_sel != frt_pkg::frt_clk_main)
            snapshot_reg <= free_counter;
    end

    // read buffer freezes on low read, thaws after high read ends
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            frozen_reg <= 1'b0;
            hi_rd_reg <= 1'b0;
        end else begin
            hi_rd_reg <= bus.rd && bus.addr == `FRT_OFF_COUNT_HI;
            if (bus.rd && bus.addr == `FRT_OFF_COUNT_LO)
                frozen_reg <= 1'b1;
            else if (hi_rd_reg && !bus.rd)
                frozen_reg <= 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            rbuf_reg <= 16'h0000;
        else if (!frozen_reg && !(bus.rd && bus.addr == `FRT_OFF_COUNT_LO))
            rbuf_reg <= free_counter;
    end

    always_comb begin
        case (bus.addr)
            `FRT_OFF_PORT_DIR: rdata_next = port_dir_reg;
            `FRT_OFF_MODE: rdata_next = {level_reg,
                mode_ctrl_reg[`FRT_B_WRAP:0]};
            `FRT_OFF_MATCH_LO: rdata_next = match_reg[7:0];
            `FRT_OFF_MATCH_HI: rdata_next = match_reg[15:8];
            `FRT_OFF_COUNT_LO: rdata_next = rbuf_reg[7:0];
            `FRT_OFF_COUNT_HI: rdata_next = rbuf_reg[15:8];
            `FRT_OFF_SNAP_LO: rdata_next = snapshot_reg[7:0];
            `FRT_OFF_SNAP_HI: rdata_next = snapshot_reg[15:8];
            default: rdata_next = 8'h00;
        endcase
    end

    // read data registered: valid the clock after rd is sampled
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            bus.rdata <= 8'h00;
        else if (bus.rd)
            bus.rdata <= rdata_next;
    end
endmodule // frt_timer
`default_nettype wire

// [frt_params.svh]
// constants for the free-running timer with capture and compare
`ifndef FRT_PARAMS_SVH
`define FRT_PARAMS_SVH
// device register offsets on the cpu-side bus
`define FRT_OFF_PORT_DIR 16'hff23
`define FRT_OFF_MODE 16'hff48
`define FRT_OFF_MATCH_LO 16'hff4a
`define FRT_OFF_MATCH_HI 16'hff4b
`define FRT_OFF_COUNT_LO 16'hff4c
`define FRT_OFF_COUNT_HI 16'hff4d
`define FRT_OFF_SNAP_LO 16'hff4e
`define FRT_OFF_SNAP_HI 16'hff4f
// reset values
`define FRT_RST_PORT_DIR 8'hff
`define FRT_RST_MODE 8'h00
`define FRT_RST_MATCH 16'hffff
`define FRT_RST_COUNT 16'h0000
// mode control fields, then the pin direction bit of the port direction register
`define FRT_B_OUT_EN 0
`define FRT_B_CLK_LO 1
`define FRT_B_CLK_HI 2
`define FRT_B_TOGGLE 3
`define FRT_B_EDGE_LO 4
`define FRT_B_EDGE_HI 5
`define FRT_B_WRAP 6
`define FRT_B_LEVEL 7
`define FRT_B_PIN_DIR 3
// clock division
`define FRT_DIV4 4
`define FRT_DIV32 32
// apb register offsets of the controller
`define FRT_APB_CMD 12'h000
`define FRT_APB_WDATA 12'h004
`define FRT_APB_RDATA 12'h008
`define FRT_APB_STATUS 12'h00c
`endif

// [frt_pkg.sv]
// types for the free-running timer
`default_nettype none
package frt_pkg;
    typedef enum logic [1:0] {
        frt_clk_ext, frt_clk_main, frt_clk_div4, frt_clk_div32
    } frt_clk_e;
    typedef enum logic [1:0] {
        frt_edge_off, frt_edge_rise, frt_edge_fall, frt_edge_both
    } frt_edge_e;
endpackage
`default_nettype wire

// [frt_bus_if.sv]
// byte-wide cpu bus between the controller and the timer
`timescale 1ns/1ps
`default_nettype none
interface frt_bus_if;
    logic [15:0] addr;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic wr;
    logic rd;
    logic match_irq;
    modport dev (input addr, input wdata, input wr, input rd,
        output rdata, output match_irq);
    modport host (output addr, output wdata, output wr, output rd,
        input rdata, input match_irq);
endinterface
`default_nettype wire

// [frt_edge_det.sv]
// synchroniser and edge detector for the capture input
`timescale 1ns/1ps
`default_nettype none
module frt_edge_det (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // pin and result
    input wire logic pin_in,
    output logic rise,
    output logic fall
);
    logic meta_reg;
    logic sync_reg;
    logic last_reg;

    // first stage feeds only the second
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_reg <= 1'b0;
            sync_reg <= 1'b0;
            last_reg <= 1'b0;
        end else begin
            meta_reg <= pin_in;
            sync_reg <= meta_reg;
            last_reg <= sync_reg;
        end
    end

    assign rise = sync_reg & ~last_reg;
    assign fall = ~sync_reg & last_reg;
endmodule // frt_edge_det
`default_nettype wire

// [frt_ctrl.sv]
// apb-controlled cpu-side master for the timer bus
`timescale 1ns/1ps
`default_nettype none
`include "frt_params.svh"
module frt_ctrl (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // timer bus
    frt_bus_if.host bus
);
    typedef enum logic [1:0] {frt_idle, frt_go, frt_wait} frt_st_e;
    frt_st_e st_reg;
    logic [15:0] addr_reg;
    logic [7:0] wdata_reg;
    logic [7:0] rdata_reg;
    logic wr_reg;
    logic irq_seen_reg;
    logic cmd_wr;
    logic stat_rd;

    assign cmd_wr = psel && penable && pwrite && paddr == `FRT_APB_CMD;
    assign stat_rd = psel && penable && !pwrite && paddr == `FRT_APB_STATUS;

    // cmd word: bit 16 write, bits 15:0 device address; starts an access
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_reg <= frt_idle;
            addr_reg <= 16'h0000;
            wr_reg <= 1'b0;
        end else begin
            case (st_reg)
                frt_idle: if (cmd_wr) begin
                    addr_reg <= pwdata[15:0];
                    wr_reg <= pwdata[16];
                    st_reg <= frt_go;
                end
                frt_go: st_reg <= frt_wait;
                frt_wait: st_reg <= frt_idle;
                default: st_reg <= frt_idle;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            wdata_reg <= 8'h00;
        else if (psel && penable && pwrite && paddr == `FRT_APB_WDATA)
            wdata_reg <= pwdata[7:0];
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            rdata_reg <= 8'h00;
        else if (st_reg == frt_wait && !wr_reg)
            rdata_reg <= bus.rdata;
    end

    // interrupt seen: set wins over the clearing status read
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            irq_seen_reg <= 1'b0;
        else if (bus.match_irq)
            irq_seen_reg <= 1'b1;
        else if (stat_rd)
            irq_seen_reg <= 1'b0;
    end

    assign bus.addr = addr_reg;
    assign bus.wdata = wdata_reg;
    assign bus.wr = st_reg == frt_go && wr_reg;
    assign bus.rd = st_reg == frt_go && !wr_reg;

    // command accepted only when idle, so the master never loses one
    assign pready = !(psel && paddr == `FRT_APB_CMD && st_reg != frt_idle);
    assign pslverr = 1'b0;

    always_comb begin
        case (paddr)
            `FRT_APB_WDATA: prdata = {24'h000000, wdata_reg};
            `FRT_APB_RDATA: prdata = {24'h000000, rdata_reg};
            `FRT_APB_STATUS: prdata = {30'h00000000, irq_seen_reg,
                st_reg != frt_idle};
            default: prdata = 32'h00000000;
        endcase
    end
endmodule // frt_ctrl
`default_nettype wire

// [frt_bus_asserts.sv]
// concurrent checks on the byte bus between controller and timer
`timescale 1ns/1ps
`default_nettype none
`include "frt_params.svh"
module frt_bus_asserts (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // timer bus
    input wire logic [15:0] addr,
    input wire logic [7:0] wdata,
    input wire logic [7:0] rdata,
    input wire logic wr,
    input wire logic rd,
    input wire logic match_irq
);
    logic [7:0] mode_reg;
    logic [7:0] dir_reg;
    // shadows of what software wrote, to predict read-back
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) mode_reg <= `FRT_RST_MODE;
        else if (wr && addr == `FRT_OFF_MODE) mode_reg <= wdata;
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) dir_reg <= `FRT_RST_PORT_DIR;
        else if (wr && addr == `FRT_OFF_PORT_DIR) dir_reg <= wdata;
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_rd(logic [15:0] a);
        rd && addr == a;
    endsequence
    a_irq_pulse: assert property (match_irq |=> !match_irq)
        else $error("match irq held over one cycle");
    a_rd_single: assert property (rd |-> !wr ##1 !rd)
        else $error("read strobe overlaps a write or repeats");
    a_wr_single: assert property (wr |=> !wr)
        else $error("write strobe repeats");
    a_rdata_hold: assert property (!rd |=> $stable(rdata))
        else $error("read data moved without a read");
    a_mode_back: assert property (s_rd(`FRT_OFF_MODE) |=>
        rdata[5:0] == mode_reg[5:0]) else $error("mode read-back wrong");
    a_out_low: assert property (s_rd(`FRT_OFF_MODE) ##0 !mode_reg[0]
        |=> !rdata[7]) else $error("level bit high while output off");
    a_dir_back: assert property (s_rd(`FRT_OFF_PORT_DIR) |=>
        rdata == {3'b111, dir_reg[4:0]})
        else $error("direction read-back wrong");
    a_unmapped_zero: assert property (rd && addr[15:4] != 12'hff4 &&
        addr != `FRT_OFF_PORT_DIR |=> rdata == 8'h00)
        else $error("unmapped read not zero");
endmodule // frt_bus_asserts
`default_nettype wire

// [frt_timer_tb.sv]
// self-checking bench for the timer driven through its apb controller
`timescale 1ns/1ps
`default_nettype none
`include "frt_params.svh"
module frt_timer_tb;
    typedef struct {logic w; logic [15:0] a; logic [7:0] d;} frt_row_s;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, q;
    logic pready, wave_out_pin, wave_out_oe;
    logic ext_tick = 1'b0, snapshot_in_pin = 1'b0, pin_latch = 1'b0;
    logic [15:0] v, c, exp_s;
    logic [7:0] b;
    int err_count = 0, samples_checked = 0, irq_n = 0, cyc = 0, t1, t2;
    frt_row_s rows [12] = '{'{1'b0, `FRT_OFF_MODE, 8'h00},
        '{1'b0, `FRT_OFF_MATCH_LO, 8'hff}, '{1'b0, `FRT_OFF_MATCH_HI, 8'hff},
        '{1'b0, `FRT_OFF_PORT_DIR, 8'hff}, '{1'b1, `FRT_OFF_MATCH_LO, 8'h00},
        '{1'b1, `FRT_OFF_MATCH_HI, 8'h00}, '{1'b0, `FRT_OFF_MATCH_LO, 8'h00},
        '{1'b0, `FRT_OFF_MATCH_HI, 8'h00}, '{1'b1, `FRT_OFF_MODE, 8'hb8},
        '{1'b0, `FRT_OFF_MODE, 8'h38}, '{1'b1, `FRT_OFF_MODE, 8'h00},
        '{1'b0, 16'hff30, 8'h00}};
    frt_bus_if bus_if ();
    frt_ctrl u_frt_ctrl (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(), .bus(bus_if));
    frt_timer u_frt_timer (.pclk(pclk), .presetn(presetn), .bus(bus_if),
        .ext_tick(ext_tick), .snapshot_in_pin(snapshot_in_pin),
        .pin_latch(pin_latch), .wave_out_pin(wave_out_pin),
        .wave_out_oe(wave_out_oe));
    frt_bus_asserts u_frt_bus_asserts (.pclk(pclk), .presetn(presetn),
        .addr(bus_if.addr), .wdata(bus_if.wdata), .rdata(bus_if.rdata),
        .wr(bus_if.wr), .rd(bus_if.rd), .match_irq(bus_if.match_irq));
    always #5 pclk = ~pclk;
    // counted on the falling edge so the comb pulse has settled
    always @(negedge pclk) begin
        cyc++;
        if (bus_if.match_irq === 1'b1) irq_n++;
    end
    // pready and prdata are taken at the rising edge that ends the access
    task automatic apb(input logic w, input logic [11:0] a,
        input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        q = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic idle;
        do apb(1'b0, `FRT_APB_STATUS, 32'h0); while (q[0] !== 1'b0);
    endtask
    task automatic dwr(input logic [15:0] a, input logic [7:0] d);
        apb(1'b1, `FRT_APB_WDATA, {24'h0, d});
        apb(1'b1, `FRT_APB_CMD, {15'h0, 1'b1, a});
        idle();
    endtask
    task automatic drd(input logic [15:0] a, output logic [7:0] d);
        apb(1'b1, `FRT_APB_CMD, {16'h0, a});
        idle();
        apb(1'b0, `FRT_APB_RDATA, 32'h0);
        d = q[7:0];
    endtask
    // low byte first: the low read freezes the count buffer
    task automatic rd16(input logic [15:0] a, output logic [15:0] d);
        drd(a, d[7:0]);
        drd(a + 16'h1, d[15:8]);
    endtask
    task automatic wr16(input logic [15:0] a, input logic [15:0] d);
        dwr(a, d[7:0]);
        dwr(a + 16'h1, d[15:8]);
    endtask
    task automatic tick(input int n);
        repeat (n) begin
            ext_tick <= 1'b1;
            @(posedge pclk);
            ext_tick <= 1'b0;
            @(posedge pclk);
        end
    endtask
    task automatic wait_irq(output int t);
        int n;
        n = irq_n;
        repeat (70000) if (irq_n == n) @(posedge pclk);
        if (irq_n == n) begin
            err_count++;
            $display("Error match interrupt expected 1 seen 0");
        end
        t = cyc;
    endtask
    task automatic chk(input string s, input logic [31:0] e,
        input logic [31:0] g);
        samples_checked++;
        if (g !== e) begin
            err_count++;
            $display("Error %s expected %h seen %h", s, e, g);
        end
    endtask
    task automatic stop_test;
        $display("checks %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    initial begin
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        foreach (rows[i]) begin
            if (rows[i].w) dwr(rows[i].a, rows[i].d);
            else begin
                drd(rows[i].a, b);
                chk("register", 32'(rows[i].d), 32'(b));
            end
        end
        $display("register table done");
        rd16(`FRT_OFF_COUNT_LO, v);
        chk("count after reset", 32'h0, 32'(v));
        tick(5);
        drd(`FRT_OFF_COUNT_LO, b);
        tick(300);
        drd(`FRT_OFF_COUNT_HI, v[15:8]);
        chk("held high byte", 32'h0, 32'(v[15:8]));
        rd16(`FRT_OFF_COUNT_LO, c);
        chk("released count", 32'd305, 32'(c));
        $display("count tests done");
        exp_s = 16'h0;
        for (int e = 0; e < 4; e++) begin
            dwr(`FRT_OFF_MODE, {2'b00, e[1:0], 4'h0});
            for (int k = 0; k < 2; k++) begin
                tick(1);
                c = c + 16'h1;
                snapshot_in_pin <= !snapshot_in_pin;
                repeat (5) @(posedge pclk);
                if (e[k]) exp_s = c;
                rd16(`FRT_OFF_SNAP_LO, v);
                chk("snapshot", 32'(exp_s), 32'(v));
            end
        end
        dwr(`FRT_OFF_MODE, 8'h32);
        snapshot_in_pin <= 1'b1;
        repeat (5) @(posedge pclk);
        dwr(`FRT_OFF_MODE, 8'h00);
        rd16(`FRT_OFF_SNAP_LO, v);
        chk("main clock capture", 32'(exp_s), 32'(v));
        $display("capture tests done");
        rd16(`FRT_OFF_COUNT_LO, c);
        dwr(`FRT_OFF_PORT_DIR, 8'hf7);
        dwr(`FRT_OFF_MODE, 8'h01);
        chk("pin on enable", 32'h2, 32'({wave_out_oe, wave_out_pin}));
        wr16(`FRT_OFF_MATCH_LO, c + 16'h1);
        dwr(`FRT_OFF_MODE, 8'h09);
        t1 = irq_n;
        tick(3);
        chk("toggled pin", 32'h1, 32'(wave_out_pin));
        drd(`FRT_OFF_MODE, b);
        chk("level bit", 32'h1, 32'(b[7]));
        dwr(`FRT_OFF_MODE, 8'h01);
        wr16(`FRT_OFF_MATCH_LO, c + 16'h4);
        tick(3);
        chk("irq count", 32'(t1 + 2), 32'(irq_n));
        chk("pin held", 32'h1, 32'(wave_out_pin));
        apb(1'b0, `FRT_APB_STATUS, 32'h0);
        chk("irq seen", 32'h1, 32'(q[1]));
        apb(1'b0, `FRT_APB_STATUS, 32'h0);
        chk("irq seen cleared", 32'h0, 32'(q[1]));
        rd16(`FRT_OFF_COUNT_LO, v);
        chk("count kept", 32'(c + 16'd6), 32'(v));
        $display("compare tests done");
        for (int s = 1; s < 4; s++) begin
            rd16(`FRT_OFF_COUNT_LO, c);
            dwr(`FRT_OFF_MODE, {5'h00, s[1:0], 1'b0});
            // 9 handshake cycles plus 119 put the mode writes 128 edges apart
            repeat (119) @(posedge pclk);
            dwr(`FRT_OFF_MODE, 8'h00);
            rd16(`FRT_OFF_COUNT_LO, v);
            exp_s = (s == 1) ? 16'd128 : (s == 2) ? 16'(128 / `FRT_DIV4)
                : 16'(128 / `FRT_DIV32);
            chk("divided count", 32'(exp_s), 32'(v - c));
        end
        $display("clock select tests done");
        dwr(`FRT_OFF_MODE, 8'h02);
        rd16(`FRT_OFF_COUNT_LO, c);
        wr16(`FRT_OFF_MATCH_LO, c + 16'd400);
        wait_irq(t1);
        wait_irq(t2);
        chk("match period", 32'd65536, 32'(t2 - t1));
        drd(`FRT_OFF_MODE, b);
        chk("wrap flag", 32'h1, 32'(b[6]));
        dwr(`FRT_OFF_MODE, 8'h02);
        drd(`FRT_OFF_MODE, b);
        chk("wrap cleared", 32'h0, 32'(b[6]));
        $display("wrap tests done");
        pin_latch <= 1'b1;
        @(posedge pclk);
        chk("port mode pin", 32'h1, 32'(wave_out_pin));
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        chk("oe in reset", 32'h0, 32'(wave_out_oe));
        presetn <= 1'b1;
        @(posedge pclk);
        rd16(`FRT_OFF_MATCH_LO, v);
        chk("match after reset", 32'hffff, 32'(v));
        drd(`FRT_OFF_MODE, b);
        chk("mode after reset", 32'h0, 32'(b));
        rd16(`FRT_OFF_COUNT_LO, v);
        chk("count after second reset", 32'h0, 32'(v));
        $display("reset tests done");
        stop_test();
    end
    // the run needs some 70000 cycles; give up at 100000
    initial begin
        #1000000;
        err_count++;
        $display("Error watchdog expired");
        stop_test();
    end
endmodule // frt_timer_tb
`default_nettype wire
